//--- design/branch_unit_pkg.sv
// Constants shared by the conditional branch unit and its condition evaluator.
// Assumes a 32-bit APB register bus with an 8-bit byte address.
package branch_unit_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET  = 8'h04;
  localparam logic [7:0] BRANCH_OFFSET = 8'h08;
  localparam logic [7:0] PC_OFFSET     = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // Field positions in the control, flag and status words.
  localparam int CTRL_KIND_LSB    = 0;
  localparam int CTRL_START_BIT   = 8;
  localparam int FLAG_NEG_BIT     = 0;
  localparam int FLAG_OVF_BIT     = 1;
  localparam int FLAG_HALF_BIT    = 2;
  localparam int FLAG_XFER_BIT    = 3;
  localparam int STATUS_BUSY_BIT  = 0;
  localparam int STATUS_TAKEN_BIT = 1;
  localparam int STATUS_DONE_BIT  = 2;
  localparam int STATUS_CYC_LSB   = 4;

  // Values after reset.
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Cycle counts of a finished branch.
  localparam logic [1:0] NOT_TAKEN_CYCLES = 2'h1;
  localparam logic [1:0] TAKEN_CYCLES     = 2'h2;

  // Branch kinds selected through the control word.
  typedef enum logic [2:0] {
    BR_SIGNED_LESS    = 3'h0,
    BR_HALF_SET       = 3'h1,
    BR_HALF_CLEAR     = 3'h2,
    BR_TRANSFER_SET   = 3'h3,
    BR_TRANSFER_CLEAR = 3'h4,
    BR_OVERFLOW_SET   = 3'h5
  } branch_kind_type;

  // Execution states, Gray coded along idle, evaluate, redirect.
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_EVAL     = 2'b01,
    ST_REDIRECT = 2'b11
  } exec_state_type;

endpackage

//--- design/branch_condition.sv
// Condition evaluator for the conditional branch unit.
// Assumes its flag inputs are held stable by the caller while it is read.
`timescale 1ns/1ps

module branch_condition
  import branch_unit_pkg::*;
(
  // Selection and status flags.
  input  wire branch_kind_type kind_in,
  input  wire logic            negative_in,
  input  wire logic            overflow_in,
  input  wire logic            half_carry_in,
  input  wire logic            transfer_in,
  // Decision.
  output logic                 take_out
);

  // Pure decode; codes outside the six kinds never branch.
  always_comb begin
    unique case (kind_in)
      BR_SIGNED_LESS:    take_out = negative_in ^ overflow_in; // see RL1
      BR_HALF_SET:       take_out = half_carry_in;             // see RL2
      BR_HALF_CLEAR:     take_out = ~half_carry_in;            // see RL3
      BR_TRANSFER_SET:   take_out = transfer_in;               // see RL4
      BR_TRANSFER_CLEAR: take_out = ~transfer_in;              // see RL5
      BR_OVERFLOW_SET:   take_out = overflow_in;               // see RL6
      default:           take_out = 1'b0;
    endcase
  end

endmodule

//--- design/branch_unit.sv
// Conditional relative-branch unit with an APB register slave.
// Assumes an APB master in the clk_in domain and synchronous inputs.
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - Signed less branch adds offset plus one when negative xor overflow is one.
// RL2 - Half carry set branch adds offset plus one when half carry is one.
// RL3 - Half carry clear branch adds offset plus one when half carry is zero.
// RL4 - Transfer bit set branch adds offset plus one when transfer bit is one.
// RL5 - Transfer bit clear branch adds offset plus one when transfer bit is zero.
// RL6 - Overflow set branch adds offset plus one when overflow is one.
// RL7 - Untaken branch takes one cycle, taken branch takes two; no flag changes.
module branch_unit
  import branch_unit_pkg::*;
#(
  parameter int PC_WIDTH     = 16,
  parameter int OFFSET_WIDTH = 7
) (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // APB slave.
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Core side.
  output logic      [PC_WIDTH-1:0] pc_out,
  output logic                     busy_out,
  output logic                     taken_out
);

  branch_kind_type         kind_q;
  logic [3:0]              flags_q;
  logic [OFFSET_WIDTH-1:0] offset_q;
  logic [PC_WIDTH-1:0]     pc_q;
  exec_state_type          state_q;
  logic                    busy_q;
  logic                    taken_q;
  logic                    done_q;
  logic [1:0]              count_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic [31:0]             prdata_q;
  logic                    take_w;
  logic                    access_w;
  logic                    write_w;
  logic                    start_w;

  // Sign-extends the offset and adds it plus one to the counter.
  function automatic logic [PC_WIDTH-1:0] redirect_target(input logic [PC_WIDTH-1:0] pc,
                                                          input logic [OFFSET_WIDTH-1:0] off);
    logic [PC_WIDTH-1:0] ext;
    ext = {{(PC_WIDTH-OFFSET_WIDTH){off[OFFSET_WIDTH-1]}}, off};
    return pc + ext + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  endfunction

  // Steps the counter to the next instruction.
  function automatic logic [PC_WIDTH-1:0] step_pc(input logic [PC_WIDTH-1:0] pc);
    return pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  endfunction

  // Tells whether a byte address hits a register.
  function automatic logic addr_ok(input logic [7:0] addr);
    return (addr == CTRL_OFFSET) || (addr == FLAGS_OFFSET) || (addr == BRANCH_OFFSET) ||
           (addr == PC_OFFSET) || (addr == STATUS_OFFSET);
  endfunction

  // Read multiplexer; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      CTRL_OFFSET:   w[CTRL_KIND_LSB +: 3] = kind_q;
      FLAGS_OFFSET:  w[3:0] = flags_q;
      BRANCH_OFFSET: w[OFFSET_WIDTH-1:0] = offset_q;
      PC_OFFSET:     w[PC_WIDTH-1:0] = pc_q;
      STATUS_OFFSET: begin
        w[STATUS_BUSY_BIT]       = busy_q;
        w[STATUS_TAKEN_BIT]      = taken_q;
        w[STATUS_DONE_BIT]       = done_q;
        w[STATUS_CYC_LSB +: 2]   = count_q;
      end
      default:       w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  branch_condition u_condition (
    .kind_in       (kind_q),
    .negative_in   (flags_q[FLAG_NEG_BIT]),
    .overflow_in   (flags_q[FLAG_OVF_BIT]),
    .half_carry_in (flags_q[FLAG_HALF_BIT]),
    .transfer_in   (flags_q[FLAG_XFER_BIT]),
    .take_out      (take_w)
  );

  // One wait state: the answer comes on the second access cycle, which eases decode timing.
  assign access_w = psel_in & penable_in & ~pready_q;
  assign write_w  = psel_in & penable_in & pready_q & pwrite_in;
  assign start_w  = write_w & (paddr_in == CTRL_OFFSET) & pwdata_in[CTRL_START_BIT] &
                    (state_q == ST_IDLE);

  // APB answer path.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access_w;
      pslverr_q <= access_w & ~addr_ok(paddr_in);
      prdata_q  <= (access_w & ~pwrite_in) ? read_word(paddr_in) : 32'h0000_0000;
    end
  end

  // Set-up registers; frozen while a branch runs so the flags it reads hold still.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      kind_q   <= BR_SIGNED_LESS;
      flags_q  <= FLAGS_RESET;
      offset_q <= '0;
    end else if (write_w && state_q == ST_IDLE) begin
      if (paddr_in == CTRL_OFFSET) begin
        kind_q <= branch_kind_type'(pwdata_in[CTRL_KIND_LSB +: 3]);
      end
      if (paddr_in == FLAGS_OFFSET) begin
        flags_q <= pwdata_in[3:0];
      end
      if (paddr_in == BRANCH_OFFSET) begin
        offset_q <= pwdata_in[OFFSET_WIDTH-1:0];
      end
    end
  end

  // Execution sequence: one cycle to evaluate, a second only when redirecting.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      count_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_w) begin
            state_q <= ST_EVAL;
            busy_q  <= 1'b1;
            count_q <= 2'h0;
          end
        end
        ST_EVAL: begin
          count_q <= count_q + 2'h1; // see RL7
          if (take_w) begin
            state_q <= ST_REDIRECT;
          end else begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        ST_REDIRECT: begin
          count_q <= count_q + 2'h1; // see RL7
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Program counter; software may load it only while idle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_q <= '0;
    end else if (state_q == ST_EVAL && !take_w) begin
      pc_q <= step_pc(pc_q);
    end else if (state_q == ST_REDIRECT) begin
      pc_q <= redirect_target(pc_q, offset_q); // see RL1 see RL2 see RL3
    end else if (write_w && paddr_in == PC_OFFSET && state_q == ST_IDLE) begin
      pc_q <= pwdata_in[PC_WIDTH-1:0];
    end
  end

  // Outcome flags; a start clears them, evaluation loads the taken flag and a finished branch sets done.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      taken_q <= 1'b0;
      done_q  <= 1'b0;
    end else if (start_w) begin
      taken_q <= 1'b0;
      done_q  <= 1'b0;
    end else if (state_q == ST_EVAL) begin
      taken_q <= take_w; // see RL4 see RL5 see RL6
      done_q  <= ~take_w;
    end else if (state_q == ST_REDIRECT) begin
      done_q  <= 1'b1;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;
  assign pc_out      = pc_q;
  assign busy_out    = busy_q;
  assign taken_out   = taken_q;

  // A taken branch redirects on its second cycle; an untaken one steps on its first.
  sequence redirect_s;
    ##1 (state_q == ST_REDIRECT) ##1 (state_q == ST_IDLE &&
      pc_q == redirect_target($past(pc_q, 2), offset_q));
  endsequence

  sequence step_s;
    ##1 (state_q == ST_IDLE && pc_q == step_pc($past(pc_q)));
  endsequence

  property branch_p(branch_kind_type k, logic c);
    @(posedge clk_in) disable iff (rst_in)
      (state_q == ST_EVAL && kind_q == k) |-> if (c) redirect_s else step_s;
  endproperty

  signed_less_a: assert property (branch_p(BR_SIGNED_LESS, // see RL1
    flags_q[FLAG_NEG_BIT] ^ flags_q[FLAG_OVF_BIT]))
    else $error("Signed less branch went the wrong way.");
  half_set_a: assert property (branch_p(BR_HALF_SET, flags_q[FLAG_HALF_BIT])) // see RL2
    else $error("Half carry set branch went the wrong way.");
  half_clear_a: assert property (branch_p(BR_HALF_CLEAR, !flags_q[FLAG_HALF_BIT])) // see RL3
    else $error("Half carry clear branch went the wrong way.");
  transfer_set_a: assert property (branch_p(BR_TRANSFER_SET, flags_q[FLAG_XFER_BIT])) // see RL4
    else $error("Transfer set branch went the wrong way.");
  transfer_clear_a: assert property (branch_p(BR_TRANSFER_CLEAR, // see RL5
    !flags_q[FLAG_XFER_BIT]))
    else $error("Transfer clear branch went the wrong way.");
  overflow_set_a: assert property (branch_p(BR_OVERFLOW_SET, flags_q[FLAG_OVF_BIT])) // see RL6
    else $error("Overflow set branch went the wrong way.");

  cycle_count_a: assert property (@(posedge clk_in) disable iff (rst_in) // see RL7
    $rose(done_q) |-> (count_q == (taken_q ? TAKEN_CYCLES : NOT_TAKEN_CYCLES)))
    else $error("Branch finished in the wrong number of cycles.");

  flags_held_a: assert property (@(posedge clk_in) disable iff (rst_in) // see RL7
    busy_q |=> $stable(flags_q))
    else $error("Status flags changed while a branch ran.");

endmodule

//--- tb/tb_conditional_branch_unit.sv
// Self-checking bench for the conditional branch unit, driven over APB.
// Assumes the branch_unit_pkg package and branch_unit are compiled first.
`timescale 1ns/1ps

// Compares two values, counts the compare and reports a mismatch.
`define CHECK(a, b, msg) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t %s", $time, msg); end end

module tb_conditional_branch_unit;
  import branch_unit_pkg::*;

  logic        clk_in;
  logic        rst_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [15:0] pc_out;
  logic        busy_out;
  logic        taken_out;
  int          n_errors;
  int          cmp_count;
  int          cycles;
  integer      seed;

  branch_unit #(.PC_WIDTH(16), .OFFSET_WIDTH(7)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pc_out(pc_out), .busy_out(busy_out), .taken_out(taken_out));

  // Free-running 25 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the full run needs far fewer cycles than this.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      final_report();
    end
  end

  // One APB transfer; an idle edge first keeps two transfers from colliding.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= addr;
    pwdata_in  <= wdata;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Waits as long as the slave needs; only the bench timeout ends a hung transfer.
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rdata      = prdata_out;
    err        = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Expected decision for each kind; codes 6 and 7 never branch.
  function automatic logic exp_take(input logic [2:0] kind, input logic [3:0] f);
    case (kind)
      3'h0:    return f[0] ^ f[1];
      3'h1:    return f[2];
      3'h2:    return ~f[2];
      3'h3:    return f[3];
      3'h4:    return ~f[3];
      3'h5:    return f[1];
      default: return 1'b0;
    endcase
  endfunction

  // Expected program counter, wrapping at 16 bits.
  function automatic logic [15:0] exp_pc(input logic [15:0] pc, input logic [6:0] k,
                                         input logic tk);
    return tk ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
  endfunction

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [2:0]  kind;
    logic [3:0]  flags;
    logic [6:0]  off;
    logic [15:0] pc;
    logic        tk;
    int          busy_n;
    seed = 41;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    `CHECK(pc_out, 16'h0000, "pc after reset")
    // An unmapped address answers with an error and reads zero.
    apb(1'b0, 8'h14, 32'h0, rd, er);
    `CHECK(er, 1'b1, "unmapped error")
    `CHECK(rd, 32'h0000_0000, "unmapped data")
    // Every kind, including the illegal codes, with random flags; offsets are 7'h40, then 7'h3F, then random.
    for (int i = 0; i < 48; i++) begin
      kind  = 3'(i % 8);
      flags = 4'($random(seed));
      off   = (i < 8) ? 7'h40 : (i < 16) ? 7'h3F : 7'($random(seed));
      pc    = (i < 8) ? 16'h0000 : (i < 16) ? 16'hFFFF : 16'($random(seed));
      tk    = exp_take(kind, flags);
      apb(1'b1, FLAGS_OFFSET, {28'h0, flags}, rd, er);
      apb(1'b1, BRANCH_OFFSET, {25'h0, off}, rd, er);
      apb(1'b1, PC_OFFSET, {16'h0, pc}, rd, er);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0100 | {29'h0, kind}, rd, er);
      busy_n = 0;
      // A branch that never starts or never ends is caught by the bench timeout.
      do begin
        @(posedge clk_in);
        if (busy_out === 1'b1) busy_n++;
      end while (busy_out === 1'b1 || busy_n == 0);
      `CHECK(pc_out, exp_pc(pc, off, tk), "pc after branch")
      `CHECK(taken_out, tk, "taken flag")
      `CHECK(busy_n, tk ? 2 : 1, "busy cycles")
      apb(1'b0, STATUS_OFFSET, 32'h0, rd, er);
      `CHECK(rd[5:4], tk ? TAKEN_CYCLES : NOT_TAKEN_CYCLES, "status cycles")
      `CHECK(rd[2:0], {1'b1, tk, 1'b0}, "status done taken busy")
      apb(1'b0, FLAGS_OFFSET, 32'h0, rd, er);
      `CHECK(rd[3:0], flags, "flags unchanged")
      `CHECK(er, 1'b0, "no error on flags")
      $display("test %0d kind %0d taken %0b ended", i, kind, tk);
    end
    final_report();
  end
endmodule
